// file: hw/csr_core_regs.sv
// Purpose: core status register and write-only option register
// Assumes: instruction fields arrive on clk from core logic; resets are synchronous events here
// Notes: flag inputs come from core logic on the same clock, so no synchronisers
// Functional notes
// - flag-affecting instruction suppresses status flag write
// - software cannot write timeout or powerdown flags
// - status bit layout and reset values
// - wake flag set by pin-wake reset or a status write; other resets clear it
// - page bit selects upper or lower program page
// - timeout flag set power-up/clear/sleep, cleared timeout
// - powerdown flag set power-up/clear, cleared sleep
// - zero flag follows zero result
// - add half-carry is nibble carry
// - subtract half-carry is inverted nibble borrow
// - carry is carry, inverted borrow, rotated bit
// - option register eight bits, write-only
// - option-load copies working register into option
// - any reset sets option to all ones
// - direction zero disables wake and pull-up
// - timer source select overrides timer pin direction
// - reset clears page select to page 0
`timescale 1ns/1ns
module csr_core_regs
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // instruction execution
  input  wire csr_pkg::csr_instr_s   instr,
  input  wire logic [7:0]            workReg,
  input  wire csr_pkg::csr_event_s   events,
  // pin control
  input  wire logic [PIN_COUNT-1:0]  pinDirectionBits,
  // outputs
  output logic [7:0]                 statusValue,
  output logic                       pageSelectBit,
  output logic [PIN_COUNT-1:0]       wakeEnable,
  output logic [PIN_COUNT-1:0]       pullupEnable,
  output logic [PIN_COUNT-1:0]       pinDirEffective,
  output logic                       timerExtClockSel
);
  import csr_pkg::*;

  logic [7:0] status_q;
  logic [7:0] option_q;
  logic [7:0] statusNext_d;
  logic       zeroNew;
  logic       halfNew;
  logic       carryNew;
  logic       affectsZ;
  logic       affectsDcC;
  logic       statusWrite;
  logic [4:0] nibSum;
  logic [8:0] fullSum;
  logic [4:0] nibDiff;
  logic [8:0] fullDiff;

  assign statusWrite = instr.valid && instr.wrEn && (instr.wrAddr == STATUS_ADDR);
  assign affectsZ    = instr.valid && (instr.aluOp == ALU_LOGIC || instr.aluOp == ALU_ADD || instr.aluOp == ALU_SUB);
  assign affectsDcC  = instr.valid && instr.aluOp != ALU_NONE && instr.aluOp != ALU_LOGIC;

  assign nibSum   = {1'b0, instr.opA[3:0]} + {1'b0, instr.opB[3:0]};
  assign fullSum  = {1'b0, instr.opA} + {1'b0, instr.opB};
  // subtract computed as a minus b with borrow detect
  assign nibDiff  = {1'b0, instr.opA[3:0]} - {1'b0, instr.opB[3:0]};
  assign fullDiff = {1'b0, instr.opA} - {1'b0, instr.opB};

  always_comb
  begin
    zeroNew  = status_q[BIT_ZERO];
    halfNew  = status_q[BIT_HALFC];
    carryNew = status_q[BIT_CARRY];
    if (affectsZ)
    begin
      zeroNew = (instr.result == 8'h00);
    end
    case (instr.aluOp)
      ALU_ADD:
      begin
        halfNew  = nibSum[4];
        carryNew = fullSum[8];
      end
      ALU_SUB:
      begin
        halfNew  = ~nibDiff[4];
        carryNew = ~fullDiff[8];
      end
      ALU_RRF:
      begin
        carryNew = instr.opA[0];
      end
      ALU_RLF:
      begin
        carryNew = instr.opA[7];
      end
      default:
      begin
        carryNew = status_q[BIT_CARRY];
      end
    endcase
    if (!affectsDcC)
    begin
      halfNew  = status_q[BIT_HALFC];
      carryNew = status_q[BIT_CARRY];
    end
    statusNext_d = status_q;
    // timeout and powerdown never take written data
    if (statusWrite)
    begin
      statusNext_d = (status_q & RO_MASK) | (instr.result & ~RO_MASK);
      statusNext_d[BIT_RSVD] = 1'b0;
      // a flag-affecting op keeps all three flags off the data path
      if (affectsZ || affectsDcC)
      begin
        statusNext_d = (statusNext_d & ~ALU_FLAGS) | (status_q & ALU_FLAGS);
      end
    end
    // flag logic wins over the data write
    if (affectsZ)
    begin
      statusNext_d[BIT_ZERO] = zeroNew;
    end
    if (affectsDcC)
    begin
      statusNext_d[BIT_HALFC] = halfNew;
      statusNext_d[BIT_CARRY] = carryNew;
    end
    if (instr.valid && (instr.watchdogClear || instr.sleep))
    begin
      statusNext_d[BIT_TIMEOUT] = 1'b1;
    end
    if (instr.valid && instr.watchdogClear)
    begin
      statusNext_d[BIT_PWRDOWN] = 1'b1;
    end
    if (instr.valid && instr.sleep)
    begin
      statusNext_d[BIT_PWRDOWN] = 1'b0;
    end
    // hardware timeout wins over a same-cycle clear instruction
    if (events.watchdogTimeout)
    begin
      statusNext_d[BIT_TIMEOUT] = 1'b0;
    end
    // device resets restart the upper bits; wake flag records cause
    // page select back to page 0
    if (events.pinWakeReset || events.otherReset || events.watchdogTimeout)
    begin
      statusNext_d[BIT_WAKE] = events.pinWakeReset;
      statusNext_d[BIT_RSVD] = 1'b0;
      statusNext_d[BIT_PAGE] = PAGE_RESET;
    end
  end

  // power-up values; ALU flags have no defined value, zero is used
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q <= STATUS_RESET;
    end
    else
    begin
      status_q <= statusNext_d;
    end
  end

  // only the option-load copies the working register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      option_q <= OPTION_RESET;
    end
    else if (events.pinWakeReset || events.otherReset || events.watchdogTimeout)
    begin
      option_q <= OPTION_RESET;
    end
    else if (instr.valid && instr.optionLoad)
    begin
      option_q <= workReg;
    end
  end

  // registered outputs; option itself is never readable
  // no read path for the option register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      statusValue      <= STATUS_RESET;
      pageSelectBit    <= PAGE_RESET;
      timerExtClockSel <= 1'b1;
    end
    else
    begin
      statusValue      <= statusNext_d;
      // page bit drives program address bit 9
      pageSelectBit    <= statusNext_d[BIT_PAGE];
      timerExtClockSel <= option_q[OPT_TMR_SRC];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : gPin
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          wakeEnable[gi]      <= 1'b0;
          pullupEnable[gi]    <= 1'b0;
          pinDirEffective[gi] <= 1'b1;
        end
        else
        begin
          // output pins lose wake and pull-up
          wakeEnable[gi]      <= pinDirectionBits[gi] & ~option_q[OPT_WAKE_N];
          pullupEnable[gi]    <= pinDirectionBits[gi] & ~option_q[OPT_PULLUP_N];
          // timer source forces the clock pin to input
          pinDirEffective[gi] <= pinDirectionBits[gi] | ((gi == TMR_PIN) && option_q[OPT_TMR_SRC]);
        end
      end
    end
  endgenerate

  chk_sleep_pd: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.sleep && !events.otherReset |=> !statusValue[BIT_PWRDOWN])
    else $error("powerdown not cleared by sleep");
  chk_wdt_to: assert property (@(posedge clk) disable iff (!reset_n)
    events.watchdogTimeout |=> !statusValue[BIT_TIMEOUT])
    else $error("timeout flag not cleared");
  chk_clr_to: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.watchdogClear && !instr.sleep && !events.watchdogTimeout
    |=> statusValue[BIT_TIMEOUT] && statusValue[BIT_PWRDOWN])
    else $error("watchdog clear did not set flags");
  chk_ro_bits: assert property (@(posedge clk) disable iff (!reset_n)
    statusWrite && !instr.watchdogClear && !instr.sleep && !events.watchdogTimeout
    |=> statusValue[4:3] == $past(status_q[4:3]))
    else $error("read-only flag written");
  chk_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
    affectsZ |=> statusValue[BIT_ZERO] == ($past(instr.result) == 8'h00))
    else $error("zero flag wrong");
  chk_flag_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !affectsZ && !affectsDcC && !statusWrite |=> statusValue[2:0] == $past(status_q[2:0]))
    else $error("alu flags changed");
  chk_option_load: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.optionLoad && !events.otherReset && !events.pinWakeReset && !events.watchdogTimeout
    |=> option_q == $past(workReg))
    else $error("option load failed");
  chk_option_rst: assert property (@(posedge clk) disable iff (!reset_n)
    events.otherReset |=> option_q == OPTION_RESET)
    else $error("option not all ones after reset");
  chk_wake_flag: assert property (@(posedge clk) disable iff (!reset_n)
    events.pinWakeReset |=> statusValue[BIT_WAKE] && !statusValue[BIT_PAGE])
    else $error("wake flag or page wrong");
  chk_pin_dir: assert property (@(posedge clk) disable iff (!reset_n)
    !pinDirectionBits[0] |=> !wakeEnable[0] && !pullupEnable[0])
    else $error("output pin kept wake or pull-up");
  chk_logic_keep: assert property (@(posedge clk) disable iff (!reset_n)
    statusWrite && affectsZ && !affectsDcC
    |=> statusValue[BIT_HALFC] == $past(status_q[BIT_HALFC]) && statusValue[BIT_CARRY] == $past(status_q[BIT_CARRY]))
    else $error("flag data write not suppressed");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !statusValue[BIT_RSVD])
    else $error("reserved bit set");
  chk_wdt_reset: assert property (@(posedge clk) disable iff (!reset_n)
    events.watchdogTimeout && !events.pinWakeReset
    |=> !statusValue[BIT_WAKE] && !pageSelectBit)
    else $error("watchdog reset kept wake or page");
  chk_option_wdt: assert property (@(posedge clk) disable iff (!reset_n)
    events.watchdogTimeout |=> option_q == OPTION_RESET)
    else $error("option not all ones after watchdog");
  chk_tmr_dir: assert property (@(posedge clk) disable iff (!reset_n)
    option_q[OPT_TMR_SRC] |=> pinDirEffective[TMR_PIN] && timerExtClockSel)
    else $error("timer pin not forced to input");
  chk_sleep_to: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.sleep && !events.watchdogTimeout |=> statusValue[BIT_TIMEOUT])
    else $error("sleep did not set timeout flag");
  chk_add_half: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.aluOp == ALU_ADD
    |=> statusValue[BIT_HALFC] == $past({1'b0, instr.opA[3:0]} + {1'b0, instr.opB[3:0]} > 5'h0F))
    else $error("add half carry wrong");
  chk_sub_half: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.aluOp == ALU_SUB
    |=> statusValue[BIT_HALFC] == $past(instr.opA[3:0] >= instr.opB[3:0]))
    else $error("subtract half carry wrong");
  chk_sub_carry: assert property (@(posedge clk) disable iff (!reset_n)
    instr.valid && instr.aluOp == ALU_SUB
    |=> statusValue[BIT_CARRY] == $past(instr.opA >= instr.opB))
    else $error("subtract carry wrong");
  chk_wake_clear: assert property (@(posedge clk) disable iff (!reset_n)
    events.otherReset && !events.pinWakeReset |=> !statusValue[BIT_WAKE])
    else $error("wake flag set by other reset");
endmodule

// file: include/csr_pkg.sv
// Purpose: constants and carriers for the core status and option registers
// Assumes: one instruction clock, asynchronous active-low reset
// Notes: status register sits at file address 03h; option register has no address
package csr_pkg;
  localparam logic [4:0] STATUS_ADDR  = 5'h03;
  localparam int         BIT_WAKE     = 7;
  localparam int         BIT_RSVD     = 6;
  localparam int         BIT_PAGE     = 5;
  localparam int         BIT_TIMEOUT  = 4;
  localparam int         BIT_PWRDOWN  = 3;
  localparam int         BIT_ZERO     = 2;
  localparam int         BIT_HALFC    = 1;
  localparam int         BIT_CARRY    = 0;
  localparam int         OPT_WAKE_N   = 7;
  localparam int         OPT_PULLUP_N = 6;
  localparam int         OPT_TMR_SRC  = 5;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] ALU_FLAGS    = 8'h07;
  localparam logic [7:0] RO_MASK      = 8'h58;
  localparam logic       PAGE_RESET   = 1'h0;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam int         PIN_COUNT    = 6;
  localparam int         TMR_PIN      = 2;

  typedef enum logic [2:0] {
    ALU_NONE  = 3'b000,
    ALU_LOGIC = 3'b001,
    ALU_ADD   = 3'b010,
    ALU_SUB   = 3'b011,
    ALU_RRF   = 3'b100,
    ALU_RLF   = 3'b101
  } csr_alu_e;

  // one executed instruction as seen by the status logic
  typedef struct packed {
    logic       valid;
    csr_alu_e   aluOp;
    logic [7:0] opA;
    logic [7:0] opB;
    logic [7:0] result;
    logic       wrEn;
    logic [4:0] wrAddr;
    logic       optionLoad;
    logic       watchdogClear;
    logic       sleep;
  } csr_instr_s;

  // hardware reset-cause events
  typedef struct packed {
    logic watchdogTimeout;
    logic pinWakeReset;
    logic otherReset;
  } csr_event_s;
endpackage

// file: bench/tb_top.sv
// Purpose: self-checking bench for the core status and option registers
// Assumes: inputs driven at the falling edge, outputs settle one edge later
// Notes: option-driven pin outputs lag the option register by one more cycle
`timescale 1ns/1ns
module tb_top;
  import csr_pkg::*;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  csr_instr_s instr = '0;
  logic [7:0] workReg = 8'h00;
  csr_event_s events = '0;
  logic [5:0] pinDir = 6'h2A;
  logic [7:0] statusValue;
  logic       pageSelectBit;
  logic [5:0] wakeEnable;
  logic [5:0] pullupEnable;
  logic [5:0] pinDirEffective;
  logic       timerExtClockSel;
  int         nMismatch = 0;
  int         nTests = 0;

  csr_core_regs i_dut (.clk(clk), .reset_n(reset_n), .instr(instr), .workReg(workReg), .events(events),
    .pinDirectionBits(pinDir), .statusValue(statusValue), .pageSelectBit(pageSelectBit),
    .wakeEnable(wakeEnable), .pullupEnable(pullupEnable), .pinDirEffective(pinDirEffective),
    .timerExtClockSel(timerExtClockSel));

  always #2 clk = ~clk;

  task automatic print_verdict();
    $display("tests=%0d mismatches=%0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one instruction, held for exactly one rising edge
  task automatic run(input csr_alu_e op, input logic [7:0] a, b, r, input logic wr, input logic [4:0] adr);
    instr = '0;
    instr.valid = 1'b1;
    instr.aluOp = op;
    instr.opA = a;
    instr.opB = b;
    instr.result = r;
    instr.wrEn = wr;
    instr.wrAddr = adr;
    @(negedge clk);
    instr = '0;
  endtask

  task automatic ctl(input logic slp, input logic clr, input logic opt);
    instr = '0;
    instr.valid = 1'b1;
    instr.sleep = slp;
    instr.watchdogClear = clr;
    instr.optionLoad = opt;
    @(negedge clk);
    instr = '0;
  endtask

  task automatic pulse(input csr_event_s e);
    events = e;
    @(negedge clk);
    events = '0;
  endtask

  task automatic t_write();
    run(ALU_NONE, 8'h00, 8'h00, 8'hBF, 1'b1, STATUS_ADDR);
    chk(statusValue, 8'hBF);
    chk({7'h00, pageSelectBit}, 8'h01);
    run(ALU_NONE, 8'h00, 8'h00, 8'h00, 1'b1, STATUS_ADDR);
    chk(statusValue, 8'h18);
  endtask

  task automatic t_alu();
    run(ALU_ADD, 8'h0F, 8'h01, 8'h10, 1'b0, 5'h00);
    chk(statusValue, 8'h1A);
    run(ALU_ADD, 8'hF0, 8'h10, 8'h00, 1'b0, 5'h00);
    chk(statusValue, 8'h1D);
    run(ALU_NONE, 8'h00, 8'h00, 8'h55, 1'b1, 5'h04);
    chk(statusValue, 8'h1D);
    run(ALU_SUB, 8'h10, 8'h01, 8'h0F, 1'b0, 5'h00);
    chk(statusValue, 8'h19);
    run(ALU_SUB, 8'h01, 8'h02, 8'hFF, 1'b0, 5'h00);
    chk(statusValue, 8'h18);
    run(ALU_SUB, 8'h05, 8'h05, 8'h00, 1'b0, 5'h00);
    chk(statusValue, 8'h1F);
    run(ALU_RRF, 8'h02, 8'h00, 8'h01, 1'b0, 5'h00);
    chk(statusValue, 8'h1E);
    run(ALU_RLF, 8'h80, 8'h00, 8'h00, 1'b0, 5'h00);
    chk(statusValue, 8'h1F);
  endtask

  task automatic t_mask();
    run(ALU_LOGIC, 8'h00, 8'h00, 8'h00, 1'b1, STATUS_ADDR);
    chk(statusValue, 8'h1F);
    run(ALU_ADD, 8'h01, 8'h01, 8'h02, 1'b1, STATUS_ADDR);
    chk(statusValue, 8'h18);
  endtask

  task automatic t_events();
    ctl(1'b1, 1'b0, 1'b0);
    chk(statusValue & RO_MASK, 8'h10);
    run(ALU_NONE, 8'h00, 8'h00, 8'hBF, 1'b1, STATUS_ADDR);
    chk(statusValue & RO_MASK, 8'h10);
    pulse('{watchdogTimeout: 1'b1, default: 1'b0});
    chk(statusValue & RO_MASK, 8'h00);
    chk(statusValue & 8'hE0, 8'h00);
    ctl(1'b0, 1'b1, 1'b0);
    chk(statusValue & RO_MASK, 8'h18);
    pulse('{otherReset: 1'b1, default: 1'b0});
    chk(statusValue & 8'hE0, 8'h00);
    pulse('{pinWakeReset: 1'b1, default: 1'b0});
    chk(statusValue & 8'hE0, 8'h80);
  endtask

  task automatic pins(input logic [5:0] wk, pu, de, input logic ts);
    chk({2'h0, wakeEnable}, {2'h0, wk});
    chk({2'h0, pullupEnable}, {2'h0, pu});
    chk({2'h0, pinDirEffective}, {2'h0, de});
    chk({7'h00, timerExtClockSel}, {7'h00, ts});
  endtask

  // the option register is write-only, so it is seen only through the pin outputs
  task automatic t_option();
    pins(6'h00, 6'h00, 6'h3F, 1'b1);
    @(negedge clk);
    pins(6'h00, 6'h00, 6'h2E, 1'b1);
    workReg = 8'h00;
    ctl(1'b0, 1'b0, 1'b1);
    @(negedge clk);
    pins(6'h2A, 6'h2A, 6'h2A, 1'b0);
    workReg = 8'hA0;
    ctl(1'b0, 1'b0, 1'b1);
    @(negedge clk);
    pins(6'h00, 6'h2A, 6'h2E, 1'b1);
    pulse('{otherReset: 1'b1, default: 1'b0});
    @(negedge clk);
    pins(6'h00, 6'h00, 6'h2E, 1'b1);
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk(statusValue, 8'h18);
    chk({7'h00, pageSelectBit}, 8'h00);
    t_option();
    t_write();
    t_alu();
    t_mask();
    t_events();
    print_verdict();
  end

  // hang guard: a stalled run counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk);
    nMismatch++;
    print_verdict();
  end
endmodule
